// ==== hw/ppp_port.v ====
`timescale 1ns/10ps
`default_nettype none
`include "ppp_defines.vh"
module ppp_port #(
  // signature and calibration values are arbitrary
  parameter [7:0] SIG0 = 8'h5A,
  parameter [7:0] SIG1 = 8'h01,
  parameter [7:0] SIG2 = 8'h02,
  parameter [7:0] CAL = 8'h80
) (
  // clock and reset
  input wire i_clk_sys,
  input wire i_rst,
  // device reset pin: logic level and programming-enable level
  input wire i_reset_pin_n,
  input wire i_reset_pin_hv,
  // strobes and selects
  input wire i_load_strobe,
  input wire i_load_action_bit0,
  input wire i_load_action_bit1,
  input wire i_byte_select_low,
  input wire i_byte_select_high,
  input wire i_page_latch_strobe,
  input wire i_wr_n,
  input wire i_oe_n,
  // data bus split into three signals
  input wire [7:0] i_data_in,
  output reg [7:0] o_data_out,
  output reg o_data_oe,
  // status
  output reg o_ready_busy_n,
  output reg o_prog_mode,
  output reg o_entry_fail
);
  localparam ENT_OFF = 2'b00;
  localparam ENT_CHK = 2'b01;
  localparam ENT_ON = 2'b10;
  localparam ENT_FAIL = 2'b11;
  localparam ST_IDLE = 3'b000;
  localparam ST_ER_FL = 3'b001;
  localparam ST_ER_EE = 3'b010;
  localparam ST_PG_FL = 3'b011;
  localparam ST_PG_EE = 3'b100;
  localparam ST_WAIT = 3'b101;
  localparam [17:0] PIN_IDLE = `PPP_PIN_IDLE;
  localparam integer ENT_CYC = `PPP_ENTRY_CYC;
  localparam [1:0] ENT_LAST = ENT_CYC[1:0] - 2'h1;

  wire [17:0] pin_raw;
  reg [17:0] s1_reg;
  reg [17:0] s2_reg;
  reg [17:0] s3_reg;
  reg [17:0] flt_reg;
  reg [17:0] dly_reg;
  assign pin_raw = {i_data_in, i_reset_pin_hv, i_reset_pin_n, i_oe_n,
    i_wr_n, i_page_latch_strobe, i_byte_select_high, i_byte_select_low,
    i_load_action_bit1, i_load_action_bit0, i_load_strobe};

  // every pin is filtered: a change counts once stages two and three agree
  genvar g;
  generate
    for (g = 0; g < 18; g = g + 1) begin : g_sync
      always @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
          s1_reg[g] <= PIN_IDLE[g];
          s2_reg[g] <= PIN_IDLE[g];
          s3_reg[g] <= PIN_IDLE[g];
          flt_reg[g] <= PIN_IDLE[g];
          dly_reg[g] <= PIN_IDLE[g];
        end else begin
          s1_reg[g] <= pin_raw[g];
          s2_reg[g] <= s1_reg[g];
          s3_reg[g] <= s2_reg[g];
          if (s2_reg[g] == s3_reg[g]) begin
            flt_reg[g] <= s3_reg[g];
          end
          dly_reg[g] <= flt_reg[g];
        end
      end
    end
  endgenerate

  wire [7:0] pin_data = flt_reg[17:10];
  wire [1:0] pin_act = flt_reg[2:1];
  wire [1:0] pin_sel = flt_reg[4:3];
  wire [3:0] pin_entry = {flt_reg[5], flt_reg[2], flt_reg[1], flt_reg[3]};
  wire ld_rise = flt_reg[0] & ~dly_reg[0];
  wire pl_rise = flt_reg[5] & ~dly_reg[5];
  // write strobe acts on its falling edge
  wire wr_fall = ~flt_reg[6] & dly_reg[6];
  wire hv_rise = flt_reg[9] & ~dly_reg[9];

  // mode entry
  reg [1:0] ent_state_reg;
  reg [1:0] ent_cnt_reg;
  reg [2:0] tog_cnt_reg;
  wire prog = (ent_state_reg == ENT_ON);
  always @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      ent_state_reg <= ENT_OFF;
      ent_cnt_reg <= 2'h0;
      tog_cnt_reg <= 3'h0;
      o_prog_mode <= 1'b0;
      o_entry_fail <= 1'b0;
    end else begin
      if (!flt_reg[9] && !flt_reg[8] && ld_rise &&
          tog_cnt_reg != `PPP_ENTRY_TOGGLES) begin
        tog_cnt_reg <= tog_cnt_reg + 3'h1;
      end else if (!flt_reg[9] && flt_reg[8]) begin
        tog_cnt_reg <= 3'h0;
      end
      case (ent_state_reg)
        ENT_OFF: begin
          if (hv_rise) begin
            ent_cnt_reg <= 2'h0;
            if (tog_cnt_reg == `PPP_ENTRY_TOGGLES && pin_entry == 4'h0) begin
              ent_state_reg <= ENT_CHK;
            end else begin
              ent_state_reg <= ENT_FAIL;
            end
          end
        end
        ENT_CHK: begin
          // entry pins must stay quiet for the settle window
          if (pin_entry != 4'h0 || !flt_reg[9]) begin
            ent_state_reg <= ENT_FAIL;
          end else if (ent_cnt_reg == ENT_LAST) begin
            ent_state_reg <= ENT_ON;
          end else begin
            ent_cnt_reg <= ent_cnt_reg + 2'h1;
          end
        end
        default: begin
          if (!flt_reg[9]) begin
            ent_state_reg <= ENT_OFF;
            tog_cnt_reg <= 3'h0;
          end
        end
      endcase
      o_prog_mode <= prog;
      o_entry_fail <= (ent_state_reg == ENT_FAIL);
    end
  end

  // pin events wait here while the buffer is full
  reg pend_valid_reg;
  reg [13:0] pend_reg;
  reg [13:0] fq0_reg;
  reg [13:0] fq1_reg;
  reg [1:0] fcnt_reg;
  reg [2:0] state_reg;
  wire ev_any = prog & (ld_rise | wr_fall | pl_rise);
  wire [1:0] ev_type = ld_rise ? `PPP_EV_LOAD :
    (wr_fall ? `PPP_EV_WR : `PPP_EV_LATCH);
  wire fifo_in_ready = (fcnt_reg != 2'h2);
  wire push = pend_valid_reg & fifo_in_ready;
  // the engine drains only when idle, so long walks stall the buffer
  wire pop = (fcnt_reg != 2'h0) & (state_reg == ST_IDLE);
  always @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      pend_valid_reg <= 1'b0;
      pend_reg <= 14'h0000;
      fq0_reg <= 14'h0000;
      fq1_reg <= 14'h0000;
      fcnt_reg <= 2'h0;
    end else begin
      if (ev_any && (!pend_valid_reg || fifo_in_ready)) begin
        pend_valid_reg <= 1'b1;
        pend_reg <= {ev_type, pin_act, pin_sel, pin_data};
      end else if (push) begin
        pend_valid_reg <= 1'b0;
      end
      if (pop) begin
        fq0_reg <= fq1_reg;
      end
      if (push && pop) begin
        if (fcnt_reg == 2'h1) begin
          fq0_reg <= pend_reg;
        end else begin
          fq1_reg <= pend_reg;
        end
      end else if (push) begin
        if (fcnt_reg == 2'h0) begin
          fq0_reg <= pend_reg;
        end else begin
          fq1_reg <= pend_reg;
        end
        fcnt_reg <= fcnt_reg + 2'h1;
      end else if (pop) begin
        fcnt_reg <= fcnt_reg - 2'h1;
      end
    end
  end

  wire [1:0] q_type = fq0_reg[13:12];
  wire [1:0] q_act = fq0_reg[11:10];
  wire [1:0] q_sel = fq0_reg[9:8];
  wire [7:0] q_data = fq0_reg[7:0];

  // command engine
  reg [7:0] cmd_reg;
  reg [7:0] addr_lo_reg;
  reg [7:0] addr_hi_reg;
  reg [7:0] addr_ext_reg;
  reg [7:0] dlo_reg;
  reg [7:0] dhi_reg;
  reg [7:0] fuse_lo_reg;
  reg [7:0] fuse_hi_reg;
  reg [7:0] fuse_ext_reg;
  reg [7:0] lock_reg;
  reg [12:0] walk_reg;
  wire [12:0] fl_addr = {addr_hi_reg[4:0], addr_lo_reg};
  wire [8:0] ee_addr = {addr_hi_reg[0], addr_lo_reg};
  always @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      cmd_reg <= 8'h00;
      addr_lo_reg <= 8'h00;
      addr_hi_reg <= 8'h00;
      addr_ext_reg <= 8'h00;
      dlo_reg <= 8'hFF;
      dhi_reg <= 8'hFF;
      fuse_lo_reg <= `PPP_FUSE_LOW_RST;
      fuse_hi_reg <= `PPP_FUSE_HIGH_RST;
      fuse_ext_reg <= `PPP_FUSE_EXT_RST;
      lock_reg <= `PPP_LOCK_RST;
      walk_reg <= 13'h0000;
      state_reg <= ST_IDLE;
      o_ready_busy_n <= 1'b1;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (pop && q_type == `PPP_EV_LOAD) begin
            // action pins pick what the load strobe stores
            // command and address stay until reloaded
            case (q_act)
              `PPP_ACT_ADDR: begin
                // byte select picks the address byte
                case (q_sel)
                  `PPP_SEL_LOW: addr_lo_reg <= q_data;
                  `PPP_SEL_HIGH: addr_hi_reg <= q_data;
                  `PPP_SEL_EXT: addr_ext_reg <= q_data;
                  default: ;
                endcase
              end
              `PPP_ACT_DATA: begin
                // low select pin picks the data byte
                if (q_sel[0]) begin
                  dhi_reg <= q_data;
                end else begin
                  dlo_reg <= q_data;
                end
              end
              `PPP_ACT_CMD: cmd_reg <= q_data;
              default: ;
            endcase
          end else if (pop && q_type == `PPP_EV_WR) begin
            walk_reg <= 13'h0000;
            // the stored command decides the write action
            case (cmd_reg)
              `PPP_CMD_ERASE: begin
                state_reg <= ST_ER_FL;
                o_ready_busy_n <= 1'b0;
              end
              `PPP_CMD_WFUSE: begin
                case (q_sel)
                  `PPP_SEL_LOW: fuse_lo_reg <= dlo_reg;
                  `PPP_SEL_HIGH: fuse_hi_reg <= dlo_reg;
                  `PPP_SEL_EXT: fuse_ext_reg <= dlo_reg;
                  default: ;
                endcase
                state_reg <= ST_WAIT;
                o_ready_busy_n <= 1'b0;
              end
              `PPP_CMD_WLOCK: begin
                // locks only program here; erase is the sole way back
                lock_reg <= lock_reg & dlo_reg;
                state_reg <= ST_WAIT;
                o_ready_busy_n <= 1'b0;
              end
              `PPP_CMD_WFLASH: begin
                // selects at 00 commit the page
                if (q_sel == `PPP_SEL_LOW) begin
                  state_reg <= ST_PG_FL;
                  o_ready_busy_n <= 1'b0;
                end
              end
              `PPP_CMD_WEE: begin
                if (q_sel == `PPP_SEL_LOW) begin
                  state_reg <= ST_PG_EE;
                  o_ready_busy_n <= 1'b0;
                end
              end
              // unknown or read command does nothing
              default: ;
            endcase
          end
        end
        ST_ER_FL: begin
          walk_reg <= walk_reg + 13'h0001;
          if (walk_reg == `PPP_FL_LAST) begin
            walk_reg <= 13'h0000;
            // programmed keep fuse (zero) skips eeprom
            if (!fuse_hi_reg[`PPP_KEEP_BIT]) begin
              // locks cleared after flash is blank
              lock_reg <= `PPP_LOCK_RST;
              state_reg <= ST_IDLE;
              o_ready_busy_n <= 1'b1;
            end else begin
              state_reg <= ST_ER_EE;
            end
          end
        end
        ST_ER_EE: begin
          walk_reg <= walk_reg + 13'h0001;
          if (walk_reg == `PPP_EE_LAST) begin
            // erase ends by clearing locks, fuses untouched
            lock_reg <= `PPP_LOCK_RST;
            state_reg <= ST_IDLE;
            o_ready_busy_n <= 1'b1;
          end
        end
        ST_PG_FL: begin
          walk_reg <= walk_reg + 13'h0001;
          if (walk_reg == `PPP_FL_PAGE_LAST) begin
            state_reg <= ST_IDLE;
            o_ready_busy_n <= 1'b1;
          end
        end
        ST_PG_EE: begin
          walk_reg <= walk_reg + 13'h0001;
          if (walk_reg == `PPP_EE_PAGE_LAST) begin
            state_reg <= ST_IDLE;
            o_ready_busy_n <= 1'b1;
          end
        end
        ST_WAIT: begin
          walk_reg <= walk_reg + 13'h0001;
          // busy held for the fixed fuse write time
          if (walk_reg[4:0] == `PPP_FUSE_CYC - 5'h01) begin
            state_reg <= ST_IDLE;
            o_ready_busy_n <= 1'b1;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
          o_ready_busy_n <= 1'b1;
        end
      endcase
    end
  end

  // memories keep no reset, like the cells they stand for
  reg [15:0] flash_mem [0:8191];
  reg [7:0] ee_mem [0:511];
  reg [15:0] fl_buf [0:63];
  reg [7:0] ee_buf [0:3];
  reg fl_we;
  reg [12:0] fl_wa;
  reg [15:0] fl_wd;
  reg ee_we;
  reg [8:0] ee_wa;
  reg [7:0] ee_wd;
  always @* begin
    fl_we = 1'b0;
    fl_wa = walk_reg;
    fl_wd = 16'hFFFF;
    ee_we = 1'b0;
    ee_wa = walk_reg[8:0];
    ee_wd = 8'hFF;
    case (state_reg)
      ST_ER_FL: fl_we = 1'b1;
      ST_ER_EE: ee_we = 1'b1;
      ST_PG_FL: begin
        // page from upper address bits, word from the walk
        fl_we = 1'b1;
        fl_wa = {fl_addr[12:6], walk_reg[5:0]};
        fl_wd = fl_buf[walk_reg[5:0]];
      end
      ST_PG_EE: begin
        ee_we = 1'b1;
        ee_wa = {ee_addr[8:2], walk_reg[1:0]};
        ee_wd = ee_buf[walk_reg[1:0]];
      end
      default: ;
    endcase
  end
  wire latch = pop & (state_reg == ST_IDLE) & (q_type == `PPP_EV_LATCH);
  always @(posedge i_clk_sys) begin
    if (fl_we) begin
      flash_mem[fl_wa] <= fl_wd;
    end
    if (ee_we) begin
      ee_mem[ee_wa] <= ee_wd;
    end
    // a written or erased slot goes blank, so a partly filled page
    // programs ones instead of stale or unknown words
    if (state_reg == ST_ER_FL || state_reg == ST_PG_FL) begin
      fl_buf[walk_reg[5:0]] <= 16'hFFFF;
    end
    if (state_reg == ST_ER_FL || state_reg == ST_PG_EE) begin
      ee_buf[walk_reg[1:0]] <= 8'hFF;
    end
    // latch stores the loaded word at the addressed slot
    if (latch && cmd_reg == `PPP_CMD_WFLASH) begin
      fl_buf[addr_lo_reg[5:0]] <= {dhi_reg, dlo_reg};
    end
    if (latch && cmd_reg == `PPP_CMD_WEE) begin
      ee_buf[addr_lo_reg[1:0]] <= dlo_reg;
    end
  end

  // read path follows the live select pins
  reg [7:0] rd_byte;
  wire [15:0] fl_rd = flash_mem[fl_addr];
  always @* begin
    rd_byte = 8'h00;
    case (cmd_reg)
      `PPP_CMD_RSIG: begin
        if (pin_sel[0]) begin
          rd_byte = CAL;
        end else if (addr_lo_reg == 8'h00) begin
          rd_byte = SIG0;
        end else if (addr_lo_reg == 8'h01) begin
          rd_byte = SIG1;
        end else if (addr_lo_reg == 8'h02) begin
          rd_byte = SIG2;
        end
      end
      `PPP_CMD_RFUSE: begin
        case (pin_sel)
          `PPP_SEL_LOW: rd_byte = fuse_lo_reg;
          `PPP_SEL_HIGH: rd_byte = lock_reg;
          `PPP_SEL_EXT: rd_byte = fuse_ext_reg;
          default: rd_byte = fuse_hi_reg;
        endcase
      end
      // low select pin picks the flash byte
      `PPP_CMD_RFLASH: rd_byte = pin_sel[0] ? fl_rd[15:8] : fl_rd[7:0];
      `PPP_CMD_REE: rd_byte = ee_mem[ee_addr];
      default: ;
    endcase
  end
  always @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_data_out <= 8'h00;
      o_data_oe <= 1'b0;
    end else begin
      o_data_out <= rd_byte;
      // drive the bus only while the read strobe is low
      o_data_oe <= prog & ~flt_reg[7];
    end
  end
endmodule // ppp_port
`default_nettype wire

// ==== hw/ppp_defines.vh ====
// What this block does
// - load strobe rise: action pins 00 address, 01 data, 10 command, 11 idle.
// - write or read strobe runs whatever the last loaded command says.
// - write commands: 80 erase, 40 fuses, 20 locks, 10 flash, 11 eeprom.
// - read commands: 08 signature/calibration, 04 fuses/locks, 02 flash, 03 eeprom.
// - address load byte select: 00 low, 01 high, 10 extended, 11 reserved.
// - fuse write selects low/high/extended; fuse read selects low/lock/ext/high.
// - flash data load and read use the low select pin for byte.
// - ready/busy low while an operation runs, high when ready.
// - data bus driven only while read strobe is low.
// - write and read strobes are active low.
// - page latch rise copies loaded data word into page buffer slot.
// - entry fails if an entry pin moves within 100 ns of enable.
// - command and address persist across operations.
// - chip erase clears flash, eeprom and locks, keeps fuses.
// - lock bits cleared only after program memory fully erased.
// - eeprom kept through erase when keep fuse is programmed.
// - erase starts on write strobe, busy low until it completes.
// - low address bits pick word in page, higher bits pick page.
// - write strobe with selects 00 commits page, busy until done.
`ifndef PPP_DEFINES_VH
`define PPP_DEFINES_VH
`define PPP_ACT_ADDR 2'b00
`define PPP_ACT_DATA 2'b01
`define PPP_ACT_CMD 2'b10
`define PPP_SEL_LOW 2'b00
`define PPP_SEL_HIGH 2'b01
`define PPP_SEL_EXT 2'b10
`define PPP_SEL_FHIGH 2'b11
`define PPP_CMD_ERASE 8'h80
`define PPP_CMD_WFUSE 8'h40
`define PPP_CMD_WLOCK 8'h20
`define PPP_CMD_WFLASH 8'h10
`define PPP_CMD_WEE 8'h11
`define PPP_CMD_RSIG 8'h08
`define PPP_CMD_RFUSE 8'h04
`define PPP_CMD_RFLASH 8'h02
`define PPP_CMD_REE 8'h03
`define PPP_EV_LOAD 2'b00
`define PPP_EV_WR 2'b01
`define PPP_EV_LATCH 2'b10
`define PPP_CLK_NS 50
`define PPP_ENTRY_NS 100
`define PPP_ENTRY_CYC ((`PPP_ENTRY_NS + `PPP_CLK_NS - 1) / `PPP_CLK_NS)
`define PPP_ENTRY_TOGGLES 3'h6
`define PPP_FUSE_CYC 5'h10
`define PPP_FL_LAST 13'h1FFF
`define PPP_EE_LAST 13'h01FF
`define PPP_FL_PAGE_LAST 13'h003F
`define PPP_EE_PAGE_LAST 13'h0003
`define PPP_FUSE_LOW_RST 8'h62
`define PPP_FUSE_HIGH_RST 8'h99
`define PPP_FUSE_EXT_RST 8'hFF
`define PPP_LOCK_RST 8'hFF
`define PPP_KEEP_BIT 3
`define PPP_PIN_IDLE 18'h0_00C0
`endif

// ==== verification/ppp_port_sva.sv ====
`timescale 1ns/10ps
`default_nettype none
module ppp_port_sva (
  // clock and reset
  input wire i_clk_sys,
  input wire i_rst,
  // pins
  input wire i_reset_pin_hv,
  input wire i_load_action_bit0,
  input wire i_load_action_bit1,
  input wire i_byte_select_low,
  input wire i_page_latch_strobe,
  input wire i_wr_n,
  input wire i_oe_n,
  // status
  input wire o_data_oe,
  input wire o_ready_busy_n,
  input wire o_prog_mode,
  input wire o_entry_fail
);
  reg [4:0] since_wr_reg;
  wire pins_zero;
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  assign pins_zero = !(i_page_latch_strobe | i_load_action_bit1 |
                       i_load_action_bit0 | i_byte_select_low);
  // saturates so a stale strobe never explains a late busy
  always @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst)
      since_wr_reg <= 5'h1F;
    else if ($fell(i_wr_n))
      since_wr_reg <= 5'h00;
    else if (since_wr_reg != 5'h1F)
      since_wr_reg <= since_wr_reg + 5'h01;
  end
  sequence s_oe_idle;
    i_oe_n [*8];
  endsequence
  sequence s_hv_idle;
    !i_reset_pin_hv [*8];
  endsequence
  // the shortest busy spell is the four-cycle eeprom page
  sequence s_busy_hold;
    !o_ready_busy_n [*4];
  endsequence
  reset_idle_a: assert property ($fell(i_rst) |-> o_ready_busy_n &&
    !o_prog_mode && !o_data_oe) else $error("outputs wrong after reset");
  oe_read_a: assert property ($rose(o_data_oe) |-> !i_oe_n &&
    !$past(i_oe_n, 3)) else $error("bus driven without read strobe");
  oe_idle_a: assert property (s_oe_idle |-> !o_data_oe)
    else $error("bus still driven after read strobe");
  mode_hv_a: assert property (s_hv_idle |-> !o_prog_mode &&
    !o_entry_fail) else $error("mode state kept without enable");
  mode_excl_a: assert property (o_entry_fail |-> !o_prog_mode)
    else $error("failed entry yet in programming mode");
  entry_pins_a: assert property ($rose(o_prog_mode) |->
    $past(pins_zero, 4) && $past(i_reset_pin_hv, 4))
    else $error("entry taken with select pins moving");
  busy_mode_a: assert property (!o_ready_busy_n |-> o_prog_mode)
    else $error("busy outside programming mode");
  busy_cause_a: assert property ($fell(o_ready_busy_n) |->
    since_wr_reg < 5'h10) else $error("busy without a write strobe");
  busy_hold_a: assert property ($fell(o_ready_busy_n) |-> s_busy_hold)
    else $error("busy pulse too short");
endmodule // ppp_port_sva
bind ppp_port ppp_port_sva u_sva (
  .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_reset_pin_hv(i_reset_pin_hv),
  .i_load_action_bit0(i_load_action_bit0),
  .i_load_action_bit1(i_load_action_bit1),
  .i_byte_select_low(i_byte_select_low),
  .i_page_latch_strobe(i_page_latch_strobe), .i_wr_n(i_wr_n),
  .i_oe_n(i_oe_n), .o_data_oe(o_data_oe), .o_ready_busy_n(o_ready_busy_n),
  .o_prog_mode(o_prog_mode), .o_entry_fail(o_entry_fail)
);
`default_nettype wire

// ==== verification/ppp_prog_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module ppp_prog_model (
  // clock
  input wire logic i_clk_sys,
  // pins toward the device
  output logic o_rst_n,
  output logic o_hv,
  output logic o_ld,
  output logic o_a0,
  output logic o_a1,
  output logic o_bsl,
  output logic o_bsh,
  output logic o_pl,
  output logic o_wr_n,
  output logic o_oe_n,
  output logic [7:0] o_data
);
  logic [7:0] last_reg = 8'h00;
  logic drive_reg = 1'b0;
  // a released bus must not look like the last byte sent
  assign o_data = drive_reg ? last_reg : ~last_reg;
  initial begin
    {o_rst_n, o_hv, o_ld, o_a0, o_a1, o_bsl, o_bsh, o_pl} = 8'h00;
    o_wr_n = 1'b1;
    o_oe_n = 1'b1;
  end
  task automatic step(input int n);
    repeat (n) @(posedge i_clk_sys);
    #1;
  endtask
  // load, latch and write strobes held 300 ns, read strobe 400 ns, data kept past the edge
  task automatic xload(input logic [1:0] act, bs, input logic [7:0] d);
    {o_a1, o_a0} = act;
    {o_bsh, o_bsl} = bs;
    last_reg = d;
    drive_reg = 1'b1;
    step(2);
    o_ld = 1'b1;
    step(6);
    o_ld = 1'b0;
    step(6);
    drive_reg = 1'b0;
    {o_a1, o_a0} = 2'b11;
    step(1);
  endtask
  task automatic latch(input logic [1:0] bs);
    {o_bsh, o_bsl} = bs;
    step(2);
    o_pl = 1'b1;
    step(6);
    o_pl = 1'b0;
    step(6);
  endtask
  task automatic wr(input logic [1:0] bs);
    {o_bsh, o_bsl} = bs;
    step(2);
    o_wr_n = 1'b0;
    step(6);
    o_wr_n = 1'b1;
    step(6);
  endtask
  task automatic rd(input logic [1:0] bs);
    {o_bsh, o_bsl} = bs;
    step(2);
    o_oe_n = 1'b0;
    step(8);
    o_oe_n = 1'b1;
    step(8);
  endtask
  // reset low, pins zero, toggles, settle, enable, then wait
  task automatic enter(input int toggles);
    {o_rst_n, o_hv, o_a1, o_a0, o_bsh, o_bsl, o_pl} = 7'h00;
    repeat (toggles) begin
      o_ld = 1'b1;
      step(6);
      o_ld = 1'b0;
      step(6);
    end
    step(4);
    o_rst_n = 1'b1;
    o_hv = 1'b1;
    step(1000);
  endtask
  task automatic leave;
    o_rst_n = 1'b0;
    o_hv = 1'b0;
    step(20);
  endtask
endmodule // ppp_prog_model
`default_nettype wire

// ==== verification/ppp_port_tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none
module ppp_port_tb_top;
  // signature and calibration values are arbitrary
  // the third byte keeps the port's own arbitrary default
  localparam logic [7:0] SIG[0:2] = '{8'h3C, 8'h4D, 8'h02};
  localparam logic [7:0] CAL = 8'h77;
  localparam logic [7:0] BAD[0:4] = '{8'h55, 8'h02, 8'h03, 8'h04, 8'h08};
  logic i_clk_sys = 1'b0;
  logic i_rst = 1'b1;
  logic rn, hv, ld, a0, a1, bsl, bsh, pl, wr_n, oe_n, d_oe, rdy, mode, ef;
  logic oe_d = 1'b0;
  logic [7:0] m_data, d_out, bus, ee;
  logic [7:0] exp_q[$];
  logic [7:0] wd[0:7];
  logic [4:0] ah;
  logic [1:0] pg;
  int fails = 0;
  int tests_run = 0;
  int n, seed;
  assign bus = d_oe ? d_out : m_data;
  always #25 i_clk_sys = ~i_clk_sys;
  ppp_port #(.SIG0(SIG[0]), .SIG1(SIG[1]), .CAL(CAL)) u_ppp_port (
    .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_reset_pin_n(rn),
    .i_reset_pin_hv(hv), .i_load_strobe(ld), .i_load_action_bit0(a0),
    .i_load_action_bit1(a1), .i_byte_select_low(bsl),
    .i_byte_select_high(bsh), .i_page_latch_strobe(pl), .i_wr_n(wr_n),
    .i_oe_n(oe_n), .i_data_in(bus), .o_data_out(d_out), .o_data_oe(d_oe),
    .o_ready_busy_n(rdy), .o_prog_mode(mode), .o_entry_fail(ef));
  ppp_prog_model u_ppp_prog_model (
    .i_clk_sys(i_clk_sys), .o_rst_n(rn), .o_hv(hv), .o_ld(ld), .o_a0(a0),
    .o_a1(a1), .o_bsl(bsl), .o_bsh(bsh), .o_pl(pl), .o_wr_n(wr_n),
    .o_oe_n(oe_n), .o_data(m_data));
  task automatic chk(input logic [7:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done;
    if (fails == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic cmd(input logic [7:0] c);
    u_ppp_prog_model.xload(2'b10, 2'b00, c);
  endtask
  task automatic adr(input logic [1:0] bs, input logic [7:0] a);
    u_ppp_prog_model.xload(2'b00, bs, a);
  endtask
  task automatic dat(input logic [1:0] bs, input logic [7:0] d);
    u_ppp_prog_model.xload(2'b01, bs, d);
  endtask
  task automatic rd(input logic [1:0] bs, input logic [7:0] e);
    exp_q.push_back(e);
    u_ppp_prog_model.rd(bs);
  endtask
  // busy is counted over a bounded window and must last lo to lo+8 cycles
  task automatic do_wr(input logic [1:0] bs, input int lo);
    n = 0;
    fork
      u_ppp_prog_model.wr(bs);
    join_none
    repeat (lo + 60) begin
      @(posedge i_clk_sys);
      if (rdy !== 1'b1)
        n++;
    end
    #1;
    chk(8'(n >= lo && n <= lo + 8), 8'h01);
  endtask
  // the byte is taken when the device starts driving the bus
  always @(posedge i_clk_sys) begin
    oe_d <= d_oe;
    if (d_oe === 1'b1 && oe_d === 1'b0)
      chk(d_out, exp_q.pop_front());
  end
  initial begin
    seed = $urandom(57525);
    repeat (8) @(posedge i_clk_sys);
    #1;
    i_rst = 1'b0;
    u_ppp_prog_model.step(1);
    chk({4'h0, mode, ef, d_oe, rdy}, 8'h01);
    u_ppp_prog_model.enter(3);
    chk({6'h00, mode, ef}, 8'h01);
    u_ppp_prog_model.leave();
    u_ppp_prog_model.enter(6);
    chk({6'h00, mode, ef}, 8'h02);
    cmd(8'h04);
    rd(2'b00, 8'h62);
    rd(2'b11, 8'h99);
    rd(2'b10, 8'hFF);
    rd(2'b01, 8'hFF);
    cmd(8'h08);
    for (int i = 0; i < 3; i++) begin
      adr(2'b00, 8'(i));
      rd(2'b00, SIG[i]);
    end
    adr(2'b00, 8'h00);
    rd(2'b01, CAL);
    foreach (BAD[i]) begin
      cmd(BAD[i]);
      do_wr(2'b00, 0);
    end
    cmd(8'h80);
    do_wr(2'b00, 8704);
    ah = 5'($urandom);
    pg = 2'($urandom);
    cmd(8'h10);
    adr(2'b10, 8'h00);
    adr(2'b01, {3'h0, ah});
    for (int w = 0; w < 4; w++) begin
      wd[2 * w] = 8'($urandom);
      wd[2 * w + 1] = 8'($urandom);
      adr(2'b00, {pg, 6'(w * 5)});
      dat(2'b00, wd[2 * w]);
      dat(2'b01, wd[2 * w + 1]);
      u_ppp_prog_model.latch(2'b01);
    end
    do_wr(2'b00, 64);
    cmd(8'h02);
    for (int w = 0; w < 4; w++) begin
      adr(2'b00, {pg, 6'(w * 5)});
      rd(2'b00, wd[2 * w]);
      rd(2'b01, wd[2 * w + 1]);
    end
    adr(2'b00, {pg, 6'h3F});
    rd(2'b00, 8'hFF);
    ee = 8'($urandom);
    cmd(8'h11);
    adr(2'b01, 8'h00);
    adr(2'b00, 8'h01);
    dat(2'b00, ee);
    u_ppp_prog_model.latch(2'b00);
    do_wr(2'b00, 4);
    cmd(8'h40);
    dat(2'b00, 8'hF7);
    do_wr(2'b01, 16);
    cmd(8'h20);
    dat(2'b00, 8'hFC);
    do_wr(2'b00, 16);
    cmd(8'h04);
    rd(2'b11, 8'hF7);
    rd(2'b01, 8'hFC);
    cmd(8'h80);
    do_wr(2'b00, 8192);
    cmd(8'h04);
    rd(2'b01, 8'hFF);
    rd(2'b11, 8'hF7);
    cmd(8'h03);
    rd(2'b00, ee);
    cmd(8'h02);
    adr(2'b01, {3'h0, ah});
    adr(2'b00, {pg, 6'h00});
    rd(2'b00, 8'hFF);
    u_ppp_prog_model.step(20);
    test_done();
  end
endmodule // ppp_port_tb_top
`default_nettype wire
